// >>> hw/pxi_cfg.svh
`ifndef PXI_CFG_SVH
`define PXI_CFG_SVH

// Register addresses
`define PXI_PEND_ADDR 8'hF2
`define PXI_EN_ADDR 8'hF1

// Reset values
`define PXI_PEND_RST 8'h00
`define PXI_EN_RST 8'h00
`define PXI_RD_RST 8'h00

// Field positions of the two pin groups
`define PXI_LOWER_MSB 3
`define PXI_LOWER_LSB 0
`define PXI_UPPER_MSB 7
`define PXI_UPPER_LSB 4

// Interrupt levels and the shared upper vector
`define PXI_LOWER_LEVEL 3'h6
`define PXI_UPPER_LEVEL 3'h7
`define PXI_UPPER_VECTOR 8'hE8

`endif

// >>> hw/pxi_pkg.sv
package pxi_pkg;

  // Per-pin two-bit mode field
  typedef enum logic [1:0] {
    PXI_MODE_FALL = 2'h0,
    PXI_MODE_BOTH = 2'h1,
    PXI_MODE_OUT = 2'h2,
    PXI_MODE_RISE = 2'h3
  } pxi_mode_type;

  // Register state of the controller
  typedef struct packed {
    logic [7:0] pend;
    logic [7:0] en;
    logic [7:0] rd_data;
    logic [7:0] upper_vec;
  } pxi_ctrl_state_type;

endpackage : pxi_pkg

// >>> hw/pxi_edge_detect.sv
module pxi_edge_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [2*WIDTH-1:0] mode_sel,
  output logic [WIDTH-1:0] edge_pulse
);

  typedef struct packed {
    logic armed;
    logic [WIDTH-1:0] prev;
  } pxi_edge_state_type;

  pxi_edge_state_type state_reg;
  pxi_edge_state_type state_next;

  // Edge decode per mode; output mode never detects
  function automatic logic edge_hit(input logic [1:0] mode, input logic prev,
                                    input logic cur);
    logic hit;
    hit = 1'b0;
    unique case (pxi_pkg::pxi_mode_type'(mode))
      pxi_pkg::PXI_MODE_FALL: hit = prev & ~cur;
      pxi_pkg::PXI_MODE_BOTH: hit = prev ^ cur;
      pxi_pkg::PXI_MODE_OUT: hit = 1'b0;
      pxi_pkg::PXI_MODE_RISE: hit = ~prev & cur;
    endcase
    return hit;
  endfunction : edge_hit

  // One detector per pin; silent until the first sample after reset
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      assign edge_pulse[gi] = state_reg.armed &
        edge_hit(mode_sel[2*gi+1:2*gi], state_reg.prev[gi], pin_in[gi]); // [RULE9]
    end
  endgenerate

  // Sample the pins every cycle
  always_comb begin
    state_next = state_reg;
    state_next.prev = pin_in;
    state_next.armed = 1'b1;
  end

  // Armed bit avoids a false edge from the reset value of prev
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : pxi_edge_detect

// >>> hw/pxi_ctrl.sv
// How it works
// RULE1: Requests from pins 3..0 go to the CPU on level six.
// RULE2: Each of the four lower sources raises its own vector request line.
// RULE3: Pending register holds one flag per pin; reads 1 when pending.
// RULE4: Flags 7..4 each track their own pin, all in the shared upper source.
// RULE5: Flags 3..0 belong to lower sources three down to zero.
// RULE6: Flag 1 shows a request detected on pin 1, source one.
// RULE7: Writing 0 clears a pending flag; writing 1 leaves it unchanged.
// RULE8: Pins 7..4 request level seven through the one common upper vector.
// RULE9: Two-bit mode picks falling, both or rising edge; output mode detects nothing.
// RULE10: A pin requests only when its enable bit and pending flag are both set.
`include "pxi_cfg.svh"

module pxi_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] pin_in,
  input wire logic [15:0] mode_sel,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic [3:0] src_req,
  output logic shared_upper_req,
  output logic irq6_req,
  output logic irq7_req,
  output logic [7:0] upper_vector
);

  pxi_pkg::pxi_ctrl_state_type state_reg;
  pxi_pkg::pxi_ctrl_state_type state_next;
  logic [7:0] edge_pulse;
  logic [7:0] active;
  logic wr_pend;
  logic wr_en;

  // Edge detection for all eight pins
  pxi_edge_detect #(
    .WIDTH(8)
  ) u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in(pin_in),
    .mode_sel(mode_sel),
    .edge_pulse(edge_pulse)
  );

  assign wr_pend = reg_wr_en && (reg_addr == `PXI_PEND_ADDR);
  assign wr_en = reg_wr_en && (reg_addr == `PXI_EN_ADDR);

  // Masked requests per pin
  assign active = state_reg.pend & state_reg.en; // [RULE10]

  // Lower pins: one line per source, all on level six
  assign src_req = active[`PXI_LOWER_MSB:`PXI_LOWER_LSB]; // [RULE2] [RULE5]
  assign irq6_req = |active[`PXI_LOWER_MSB:`PXI_LOWER_LSB]; // [RULE1]

  // Upper pins merge into one source on level seven
  assign shared_upper_req = |active[`PXI_UPPER_MSB:`PXI_UPPER_LSB]; // [RULE4]
  assign irq7_req = shared_upper_req; // [RULE8]
  assign upper_vector = state_reg.upper_vec;
  assign reg_rd_data = state_reg.rd_data;

  // Register updates; a new edge beats a clearing write
  always_comb begin
    state_next = state_reg;
    if (wr_pend) begin
      state_next.pend = state_reg.pend & reg_wr_data; // [RULE7]
    end
    state_next.pend = state_next.pend | edge_pulse; // [RULE3] [RULE6]
    if (wr_en) begin
      state_next.en = reg_wr_data;
    end
    // Read returns the value before any write in the same cycle
    if (reg_rd_en) begin
      unique case (reg_addr)
        `PXI_PEND_ADDR: state_next.rd_data = state_reg.pend; // [RULE3]
        `PXI_EN_ADDR: state_next.rd_data = state_reg.en;
        default: state_next.rd_data = 8'h00;
      endcase
    end
    state_next.upper_vec = `PXI_UPPER_VECTOR; // [RULE8]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.pend <= `PXI_PEND_RST;
      state_reg.en <= `PXI_EN_RST;
      state_reg.rd_data <= `PXI_RD_RST;
      state_reg.upper_vec <= `PXI_UPPER_VECTOR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Checks on the running block
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Enabled edge on a lower pin reaches level six next cycle
  property p_lvl6_from_edge;
    (|(edge_pulse[3:0] & state_reg.en[3:0])) && !wr_en |=> irq6_req;
  endproperty
  a_lvl6_from_edge: assert property (p_lvl6_from_edge) // [RULE1]
    else $error("lower edge did not raise level six");

  // A source line only rises after its own pin edge or an enable write
  property p_src0_cause;
    $rose(src_req[0]) |-> $past(edge_pulse[0]) || $past(wr_en);
  endproperty
  a_src0_cause: assert property (p_src0_cause) // [RULE2]
    else $error("source zero request without cause");

  // Reading the pending register returns the flags
  property p_read_pend;
    reg_rd_en && (reg_addr == `PXI_PEND_ADDR) |=> reg_rd_data == $past(state_reg.pend);
  endproperty
  a_read_pend: assert property (p_read_pend) // [RULE3]
    else $error("pending read data wrong");

  // Pin five edge sets flag five and, if pin five is enabled, the shared upper source
  property p_pin5_flag;
    edge_pulse[5] |=> state_reg.pend[5] && (!state_reg.en[5] || shared_upper_req);
  endproperty
  a_pin5_flag: assert property (p_pin5_flag) // [RULE4]
    else $error("pin five edge lost");

  // Pin three edge with no pending-register write sets flag three
  property p_pin3_flag;
    edge_pulse[3] && !wr_pend |=> state_reg.pend[3];
  endproperty
  a_pin3_flag: assert property (p_pin3_flag) // [RULE5]
    else $error("pin three edge lost");

  // Pin one edge wins even against a clearing write
  property p_pin1_set_wins;
    edge_pulse[1] && wr_pend && !reg_wr_data[1] |=> state_reg.pend[1];
  endproperty
  a_pin1_set_wins: assert property (p_pin1_set_wins) // [RULE6]
    else $error("pin one edge lost to clear");

  // Write without edges: zeros clear, ones keep
  property p_write_clear;
    wr_pend && (edge_pulse == 8'h00) |=>
      state_reg.pend == ($past(state_reg.pend) & $past(reg_wr_data));
  endproperty
  a_write_clear: assert property (p_write_clear) // [RULE7]
    else $error("pending write effect wrong");

  // Level seven always carries the common upper vector
  property p_upper_vec;
    irq7_req |-> upper_vector == 8'hE8 && |state_reg.pend[7:4];
  endproperty
  a_upper_vec: assert property (p_upper_vec) // [RULE8]
    else $error("upper request vector wrong");

  // Output mode pins never newly pend
  property p_out_mode;
    $rose(state_reg.pend[0]) |-> $past(mode_sel[1:0]) != 2'h2;
  endproperty
  a_out_mode: assert property (p_out_mode) // [RULE9]
    else $error("output mode pin raised a flag");

  // Clearing all enables silences both levels
  property p_mask_all;
    wr_en && (reg_wr_data == 8'h00) |=> !irq6_req && !irq7_req && src_req == 4'h0;
  endproperty
  a_mask_all: assert property (p_mask_all) // [RULE10]
    else $error("masked pins still request");

  // Read data only moves on a read strobe, so software may sample it late
  property p_rd_hold;
    !reg_rd_en |=> $stable(reg_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) // [RULE3]
    else $error("read data moved without a read");

  // A one written over a set flag must not clear it
  property p_keep_one;
    wr_pend && reg_wr_data[4] && state_reg.pend[4] |=> state_reg.pend[4];
  endproperty
  a_keep_one: assert property (p_keep_one) // [RULE7]
    else $error("writing one cleared a flag");

  // Enabled edge on an upper pin reaches level seven next cycle
  property p_lvl7_from_edge;
    (|(edge_pulse[7:4] & state_reg.en[7:4])) && !wr_en |=> irq7_req;
  endproperty
  a_lvl7_from_edge: assert property (p_lvl7_from_edge) // [RULE8]
    else $error("upper edge did not raise level seven");

  // Source three has its own line, raised only by its own pin or an enable write
  property p_src3_cause;
    $rose(src_req[3]) |-> $past(edge_pulse[3]) || $past(wr_en);
  endproperty
  a_src3_cause: assert property (p_src3_cause) // [RULE2]
    else $error("source three request without cause");

  // Enable register takes the whole written byte
  property p_en_write;
    wr_en |=> state_reg.en == $past(reg_wr_data);
  endproperty
  a_en_write: assert property (p_en_write) // [RULE10]
    else $error("enable write lost");

  // Upper flags only rise from their own pin, never from a write
  property p_pend6_cause;
    $rose(state_reg.pend[6]) |-> $past(edge_pulse[6]);
  endproperty
  a_pend6_cause: assert property (p_pend6_cause) // [RULE4]
    else $error("flag six set without an edge");

  // Clearing every flag with no new edge drops both levels
  property p_clear_all;
    wr_pend && (reg_wr_data == 8'h00) && (edge_pulse == 8'h00) |=> !irq6_req && !irq7_req;
  endproperty
  a_clear_all: assert property (p_clear_all) // [RULE7]
    else $error("requests survive a full clear");

  c_lvl6: cover property (edge_pulse[2] && state_reg.en[2] ##1 irq6_req);
  c_lvl7: cover property (edge_pulse[6] && state_reg.en[6] ##1 irq7_req);
  c_clear: cover property (irq6_req && wr_pend ##1 !irq6_req);
  c_collide: cover property (edge_pulse[1] && wr_pend && !reg_wr_data[1]);
  c_keep_one: cover property (wr_pend && reg_wr_data[4] && state_reg.pend[4]);

endmodule : pxi_ctrl

// >>> sim/pxi_pin_model.sv
module pxi_pin_model (
  input wire logic clk,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins rest low until the bench asks for an edge
  initial pins = 8'h00;

  // Launched just after the edge so the block sees a clean level for a whole cycle
  task automatic flip(input logic [7:0] mask);
    @(posedge clk);
    pins <= pins ^ mask;
  endtask : flip
endmodule : pxi_pin_model

// >>> sim/pxi_ctrl_tb.sv
`include "pxi_cfg.svh"

module pxi_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, arst_n, reg_wr_en, reg_rd_en, irq6_req, irq7_req, shared_upper_req;
  logic [7:0] pin_in, reg_addr, reg_wr_data, reg_rd_data, upper_vector;
  logic [15:0] mode_sel;
  logic [3:0] src_req;
  wire logic [7:0] reqs;
  int miscompares = 0;
  int samples_checked = 0;
  // Each row: mode, then the pins toggle, then the flags expected
  pxi_pkg::pxi_mode_type mtab [7] = '{pxi_pkg::PXI_MODE_RISE, pxi_pkg::PXI_MODE_RISE,
    pxi_pkg::PXI_MODE_FALL, pxi_pkg::PXI_MODE_FALL, pxi_pkg::PXI_MODE_BOTH,
    pxi_pkg::PXI_MODE_BOTH, pxi_pkg::PXI_MODE_OUT};
  logic [7:0] etab [7] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};

  // All request outputs gathered so one compare covers them
  assign reqs = {irq7_req, irq6_req, shared_upper_req, 1'b0, src_req};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  pxi_ctrl dut_u (.clk, .arst_n, .pin_in, .mode_sel, .reg_addr, .reg_wr_en, .reg_rd_en,
    .reg_wr_data, .reg_rd_data, .src_req, .shared_upper_req, .irq6_req, .irq7_req,
    .upper_vector);

  pxi_pin_model pin_u (.clk, .pins(pin_in));

  function automatic logic [7:0] exp_req(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] m;
    m = p & e;
    return {|m[7:4], |m[3:0], |m[7:4], 1'b0, m[3:0]};
  endfunction : exp_req

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  // Data is registered one cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(negedge clk);
    chk(reg_rd_data, exp);
  endtask : rd

  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // Tests need well under 400 cycles; ten times that means a hang
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    arst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    mode_sel = 16'h0000;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // Reset state, fixed vector and an unmapped read
    rd(`PXI_PEND_ADDR, 8'h00);
    rd(`PXI_EN_ADDR, 8'h00);
    chk(upper_vector, 8'hE8);
    rd(8'h10, 8'h00);
    wr(`PXI_EN_ADDR, 8'hFF);
    // Rise, fall and both modes in both directions; output mode, rising only, must stay silent
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      mode_sel <= {8{mtab[i]}};
      pin_u.flip(8'hFF);
      repeat (3) @(posedge clk);
      rd(`PXI_PEND_ADDR, etab[i]);
      chk(reqs, exp_req(etab[i], 8'hFF));
      wr(`PXI_PEND_ADDR, 8'h00);
    end
    // One pin at a time must land on its own flag and source
    mode_sel <= {8{pxi_pkg::PXI_MODE_BOTH}};
    for (int i = 0; i < 8; i++) begin
      pin_u.flip(8'h01 << i);
      repeat (3) @(posedge clk);
      rd(`PXI_PEND_ADDR, 8'h01 << i);
      chk(reqs, exp_req(8'h01 << i, 8'hFF));
      wr(`PXI_PEND_ADDR, 8'h00);
    end
    // Mixed modes: each field must steer only its own pin
    mode_sel <= 16'hE3D3;
    pin_u.flip(8'hFF);
    repeat (3) @(posedge clk);
    rd(`PXI_PEND_ADDR, 8'h9D);
    wr(`PXI_PEND_ADDR, 8'h00);
    mode_sel <= {8{pxi_pkg::PXI_MODE_BOTH}};
    // Ones are ignored; a zero clears only its own bit
    pin_u.flip(8'hFF);
    repeat (3) @(posedge clk);
    wr(`PXI_PEND_ADDR, 8'hFF);
    rd(`PXI_PEND_ADDR, 8'hFF);
    wr(`PXI_PEND_ADDR, 8'hFD);
    rd(`PXI_PEND_ADDR, 8'hFD);
    // Masking splits the lower and upper groups
    wr(`PXI_EN_ADDR, 8'h0A);
    rd(`PXI_EN_ADDR, 8'h0A);
    chk(reqs, exp_req(8'hFD, 8'h0A));
    wr(`PXI_EN_ADDR, 8'h20);
    rd(`PXI_EN_ADDR, 8'h20);
    chk(reqs, exp_req(8'hFD, 8'h20));
    give_verdict();
  end
endmodule : pxi_ctrl_tb
